// File: shared/csc_cfg.svh
// Constants for the command source combiner: register map, fields, resets.
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

`define CSC_ADDR_W 4
`define CSC_DATA_W 16

`define CSC_REG_MODE 4'h0
`define CSC_REG_SER 4'h1
`define CSC_REG_STAT 4'h2

`define CSC_MODE_W 6
`define CSC_MODE_DIR_LSB 0
`define CSC_MODE_SET_LSB 2
`define CSC_MODE_PRE_LSB 4
`define CSC_MODE_RST 6'h3c

`define CSC_SER_W 5
`define CSC_SER_DIR_BIT 0
`define CSC_SER_SET_LSB 1
`define CSC_SER_PRE_LSB 3
`define CSC_SER_RST 5'h00

`define CSC_ST_DIR_BIT 0
`define CSC_ST_SET_LSB 1
`define CSC_ST_PRE_LSB 4
`define CSC_ST_TDIR_BIT 7
`define CSC_ST_TSET_LSB 8
`define CSC_ST_TPRE_LSB 10

`define CSC_NUM_W 3
`define CSC_NUM_RST 3'h1
`define CSC_NUM_ONE 3'h1
`define CSC_NUM_MAX 3'h4
`define CSC_CODE_W 2
`define CSC_FIELDS 3

`endif

// File: shared/csc_pkg.sv
// Types and shared decoding functions of the command source combiner.
`include "csc_cfg.svh"

package csc_pkg;

   typedef enum logic [1:0] {
      CSC_MODE_TERM,
      CSC_MODE_SER,
      CSC_MODE_AND,
      CSC_MODE_OR
   } csc_mode_t;

   typedef struct packed {
      logic [`CSC_MODE_W-1:0] mode;
      logic [`CSC_SER_W-1:0] ser;
   } csc_regs_st_t;

   typedef struct packed {
      logic dir_ccw;
      logic [`CSC_NUM_W-1:0] setup_num;
      logic [`CSC_NUM_W-1:0] preset_num;
      logic [`CSC_DATA_W-1:0] rdata;
   } csc_top_st_t;

   // One result bit from its terminal and serial sources.
   function automatic logic csc_mix_bit(input csc_mode_t m, input logic t, input logic s);
      logic r;
      r = 1'b0;
      case (m)
         CSC_MODE_TERM: r = t;
         CSC_MODE_SER: r = s;
         CSC_MODE_AND: r = t & s;
         CSC_MODE_OR: r = t | s;
         default: r = t;
      endcase
      return r;
   endfunction

   // Selection code 00..11 to number 1..4.
   function automatic logic [`CSC_NUM_W-1:0] csc_num(input logic [`CSC_CODE_W-1:0] code);
      return {1'b0, code} + `CSC_NUM_ONE;
   endfunction

endpackage

// File: shared/csc_mix_if.sv
// Interface carrying one field's mode, sources and combined result.
`timescale 1ns/10ps

interface csc_mix_if #(
   parameter int W = 2
);
   logic [1:0] mode;
   logic [W-1:0] term;
   logic [W-1:0] ser;
   logic [W-1:0] res;

   modport src (
      output mode,
      output term,
      output ser,
      input res
   );

   modport mix (
      input mode,
      input term,
      input ser,
      output res
   );
endinterface

// File: design/csc_mix.sv
// Bitwise source combiner for one selection field.
`timescale 1ns/10ps

module csc_mix
   import csc_pkg::*;
#(
   parameter int W = 2
) (
   csc_mix_if.mix m
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign m.res[i] = csc_mix_bit(csc_mode_t'(m.mode), m.term[i], m.ser[i]);
      end
   endgenerate
endmodule

// File: design/csc_regs.sv
// Software-writable mode and serial command registers.
`timescale 1ns/10ps

module csc_regs
   import csc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic wr_stb,
   input wire logic [`CSC_ADDR_W-1:0] addr,
   input wire logic [`CSC_DATA_W-1:0] wdata,
   output logic [`CSC_MODE_W-1:0] mode_q,
   output logic [`CSC_SER_W-1:0] ser_q
);
   csc_regs_st_t st_q;
   csc_regs_st_t st_d;

   always_comb begin
      st_d = st_q;
      if (wr_stb && addr == `CSC_REG_MODE) begin
         st_d.mode = wdata[`CSC_MODE_W-1:0];
      end
      if (wr_stb && addr == `CSC_REG_SER) begin
         st_d.ser = wdata[`CSC_SER_W-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         st_q.mode <= `CSC_MODE_RST;
         st_q.ser <= `CSC_SER_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign mode_q = st_q.mode;
   assign ser_q = st_q.ser;
endmodule

// File: design/csc_top.sv
// Command source combiner: merges terminal and serial direction and selection commands.
//
// Behaviour
// - Reversing source mode has four codes.
// - Terminal mode: terminal sets direction, serial ignored.
// - Serial mode: serial bit sets direction.
// - AND mode: counter-clockwise only when both set.
// - OR mode: counter-clockwise when either set.
// - Setup and preset have own four-code modes.
// - Two-bit combined code plus one gives setup.
// - Same combining picks one of four presets.
// - Terminal mode uses only terminal pair.
// - Serial mode uses only serial pair.
// - AND mode combines bits bitwise AND.
// - Serial needs serial command; AND needs both.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps

module csc_top
   import csc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [`CSC_ADDR_W-1:0] reg_addr,
   input wire logic [`CSC_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`CSC_DATA_W-1:0] reg_rdata,
   input wire logic reverse_terminal_input,
   input wire logic [`CSC_CODE_W-1:0] setup_terminal_code,
   input wire logic [`CSC_CODE_W-1:0] preset_terminal_code,
   output logic dir_ccw,
   output logic [`CSC_NUM_W-1:0] setup_num,
   output logic [`CSC_NUM_W-1:0] preset_num
);

   csc_top_st_t st_q;
   csc_top_st_t st_d;

   logic [`CSC_MODE_W-1:0] mode_q;
   logic [`CSC_SER_W-1:0] ser_q;

   csc_mode_t dir_mode;
   csc_mode_t set_mode;
   csc_mode_t pre_mode;

   logic ser_dir;
   logic [`CSC_CODE_W-1:0] ser_set;
   logic [`CSC_CODE_W-1:0] ser_pre;

   // Per-field views, indexed 0 direction, 1 setup, 2 preset.
   logic [1:0] fld_mode [`CSC_FIELDS];
   logic [`CSC_CODE_W-1:0] fld_term [`CSC_FIELDS];
   logic [`CSC_CODE_W-1:0] fld_ser [`CSC_FIELDS];
   logic [`CSC_CODE_W-1:0] fld_res [`CSC_FIELDS];

   logic [`CSC_DATA_W-1:0] status;

   csc_regs u_regs (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .wr_stb(reg_wr),
      .addr(reg_addr),
      .wdata(reg_wdata),
      .mode_q(mode_q),
      .ser_q(ser_q)
   );

   assign dir_mode = csc_mode_t'(mode_q[`CSC_MODE_DIR_LSB +: `CSC_CODE_W]);
   assign set_mode = csc_mode_t'(mode_q[`CSC_MODE_SET_LSB +: `CSC_CODE_W]);
   assign pre_mode = csc_mode_t'(mode_q[`CSC_MODE_PRE_LSB +: `CSC_CODE_W]);

   assign ser_dir = ser_q[`CSC_SER_DIR_BIT];
   assign ser_set = ser_q[`CSC_SER_SET_LSB +: `CSC_CODE_W];
   assign ser_pre = ser_q[`CSC_SER_PRE_LSB +: `CSC_CODE_W];

   // The direction rides in bit 0 of a two-bit field so that one combiner shape serves all three.
   always_comb begin
      fld_mode[0] = dir_mode;
      fld_term[0] = {1'b0, reverse_terminal_input};
      fld_ser[0] = {1'b0, ser_dir};
      fld_mode[1] = set_mode;
      fld_term[1] = setup_terminal_code;
      fld_ser[1] = ser_set;
      fld_mode[2] = pre_mode;
      fld_term[2] = preset_terminal_code;
      fld_ser[2] = ser_pre;
   end

   genvar f;
   generate
      for (f = 0; f < `CSC_FIELDS; f++) begin : g_fld
         csc_mix_if #(.W(`CSC_CODE_W)) mix_if ();
         assign mix_if.mode = fld_mode[f];
         assign mix_if.term = fld_term[f];
         assign mix_if.ser = fld_ser[f];
         assign fld_res[f] = mix_if.res;
         csc_mix #(.W(`CSC_CODE_W)) u_mix (
            .m(mix_if.mix)
         );
      end
   endgenerate

   always_comb begin
      status = '0;
      status[`CSC_ST_DIR_BIT] = st_q.dir_ccw;
      status[`CSC_ST_SET_LSB +: `CSC_NUM_W] = st_q.setup_num;
      status[`CSC_ST_PRE_LSB +: `CSC_NUM_W] = st_q.preset_num;
      status[`CSC_ST_TDIR_BIT] = reverse_terminal_input;
      status[`CSC_ST_TSET_LSB +: `CSC_CODE_W] = setup_terminal_code;
      status[`CSC_ST_TPRE_LSB +: `CSC_CODE_W] = preset_terminal_code;
   end

   // Results follow the sources one clock later; no filtering, so a terminal glitch
   // that is sampled on an edge reaches the outputs.
   always_comb begin
      st_d = st_q;
      st_d.dir_ccw = fld_res[0][0];
      st_d.setup_num = csc_num(fld_res[1]);
      st_d.preset_num = csc_num(fld_res[2]);
      st_d.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            `CSC_REG_MODE: st_d.rdata = {{(`CSC_DATA_W-`CSC_MODE_W){1'b0}}, mode_q};
            `CSC_REG_SER: st_d.rdata = {{(`CSC_DATA_W-`CSC_SER_W){1'b0}}, ser_q};
            `CSC_REG_STAT: st_d.rdata = status;
            default: st_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         st_q.dir_ccw <= 1'b0;
         st_q.setup_num <= `CSC_NUM_RST;
         st_q.preset_num <= `CSC_NUM_RST;
         st_q.rdata <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign dir_ccw = st_q.dir_ccw;
   assign setup_num = st_q.setup_num;
   assign preset_num = st_q.preset_num;
   assign reg_rdata = st_q.rdata;

   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (!nrst);

   mode_write_a: assert property (
      (reg_wr && reg_addr == `CSC_REG_MODE)
      |=> (mode_q == $past(reg_wdata[`CSC_MODE_W-1:0]))
   ) else $error("mode register did not take the written value");

   mode_fields_a: assert property (
      (reg_wr && reg_addr == `CSC_REG_MODE)
      |=> (set_mode == csc_mode_t'($past(reg_wdata[`CSC_MODE_SET_LSB +: 2])))
      && (pre_mode == csc_mode_t'($past(reg_wdata[`CSC_MODE_PRE_LSB +: 2])))
   ) else $error("setup or preset mode field misplaced");

   term_dir_a: assert property (
      (dir_mode == CSC_MODE_TERM)
      |=> (dir_ccw == $past(reverse_terminal_input))
   ) else $error("terminal-only direction does not follow terminal");

   ser_dir_a: assert property (
      (dir_mode == CSC_MODE_SER)
      |=> (dir_ccw == $past(ser_dir))
   ) else $error("serial-only direction does not follow serial bit");

   and_dir_a: assert property (
      (dir_mode == CSC_MODE_AND)
      |=> (dir_ccw == ($past(ser_dir) && $past(reverse_terminal_input)))
   ) else $error("AND direction wrong");

   or_dir_a: assert property (
      (dir_mode == CSC_MODE_OR)
      |=> (dir_ccw == ($past(ser_dir) || $past(reverse_terminal_input)))
   ) else $error("OR direction wrong");

   setup_range_a: assert property (
      (setup_num >= `CSC_NUM_ONE) && (setup_num <= `CSC_NUM_MAX)
      && (preset_num >= `CSC_NUM_ONE) && (preset_num <= `CSC_NUM_MAX)
   ) else $error("selection number out of 1..4");

   preset_code_a: assert property (
      (pre_mode == CSC_MODE_TERM && preset_terminal_code == 2'h3)
      |=> (preset_num == `CSC_NUM_MAX)
   ) else $error("preset code 11 did not choose the fourth preset");

   term_sel_a: assert property (
      (set_mode == CSC_MODE_TERM)
      |=> (setup_num == csc_num($past(setup_terminal_code)))
   ) else $error("terminal-only setup ignores terminal pair");

   ser_sel_a: assert property (
      (pre_mode == CSC_MODE_SER)
      |=> (preset_num == csc_num($past(ser_pre)))
   ) else $error("serial-only preset ignores serial pair");

   and_sel_a: assert property (
      (set_mode == CSC_MODE_AND)
      |=> (setup_num == csc_num($past(ser_set) & $past(setup_terminal_code)))
   ) else $error("AND setup selection wrong");

   or_sel_a: assert property (
      (pre_mode == CSC_MODE_OR)
      |=> (preset_num == csc_num($past(ser_pre) | $past(preset_terminal_code)))
   ) else $error("OR preset selection wrong");

   ser_needed_a: assert property (
      (dir_mode inside {CSC_MODE_SER, CSC_MODE_AND} && !ser_dir)
      |=> !dir_ccw
   ) else $error("direction changed without a serial command");

   and_needs_term_a: assert property (
      (dir_mode == CSC_MODE_AND && !reverse_terminal_input)
      |=> !dir_ccw
   ) else $error("AND direction active without the terminal");

   reset_out_a: assert property (
      @(posedge sys_clk) disable iff (1'b0)
      !nrst |=> (!dir_ccw && setup_num == `CSC_NUM_RST && preset_num == `CSC_NUM_RST)
   ) else $error("outputs not at clockwise, setup 1, preset 1 after reset");

   ser_write_follow_a: assert property (
      (reg_wr && reg_addr == `CSC_REG_SER && dir_mode == CSC_MODE_SER)
      ##1 (dir_mode == CSC_MODE_SER && !reg_wr)
      |=> (dir_ccw == $past(reg_wdata[`CSC_SER_DIR_BIT], 2))
   ) else $error("serial direction did not reach the output two edges after the write");

   read_stat_a: assert property (
      (reg_rd && reg_addr == `CSC_REG_STAT)
      |=> (reg_rdata == $past(status))
   ) else $error("status read data wrong");

   read_idle_a: assert property (
      !reg_rd |=> (reg_rdata == '0)
   ) else $error("read data not zero outside the read answer cycle");

   term_pre_a: assert property (
      (pre_mode == CSC_MODE_TERM)
      |=> (preset_num == csc_num($past(preset_terminal_code)))
   ) else $error("terminal-only preset ignores terminal pair");

   ser_set_a: assert property (
      (set_mode == CSC_MODE_SER)
      |=> (setup_num == csc_num($past(ser_set)))
   ) else $error("serial-only setup ignores serial pair");

   and_pre_a: assert property (
      (pre_mode == CSC_MODE_AND)
      |=> (preset_num == csc_num($past(ser_pre) & $past(preset_terminal_code)))
   ) else $error("AND preset selection wrong");

   or_set_a: assert property (
      (set_mode == CSC_MODE_OR)
      |=> (setup_num == csc_num($past(ser_set) | $past(setup_terminal_code)))
   ) else $error("OR setup selection wrong");

   // Worked cases pin the msb and lsb order of both pairs, which a swapped index would break.
   and_example_a: assert property (
      (set_mode == CSC_MODE_AND && ser_set == 2'h1 && setup_terminal_code == 2'h3)
      |=> (setup_num == 3'h2)
   ) else $error("AND of serial 01 and terminal 11 did not give setup 2");

   or_example_a: assert property (
      (pre_mode == CSC_MODE_OR && ser_pre == 2'h1 && preset_terminal_code == 2'h2)
      |=> (preset_num == `CSC_NUM_MAX)
   ) else $error("OR of serial 01 and terminal 10 did not give preset 4");

   setup_one_a: assert property (
      (set_mode == CSC_MODE_TERM && setup_terminal_code == 2'h0)
      |=> (setup_num == `CSC_NUM_ONE)
   ) else $error("code 00 did not choose setup 1");

   setup_four_a: assert property (
      (set_mode == CSC_MODE_TERM && setup_terminal_code == 2'h3)
      |=> (setup_num == `CSC_NUM_MAX)
   ) else $error("code 11 did not choose setup 4");

   preset_one_a: assert property (
      (pre_mode == CSC_MODE_TERM && preset_terminal_code == 2'h0)
      |=> (preset_num == `CSC_NUM_ONE)
   ) else $error("code 00 did not choose the first preset");

   term_dir_low_a: assert property (
      (dir_mode == CSC_MODE_TERM && !reverse_terminal_input)
      |=> !dir_ccw
   ) else $error("terminal-only direction not clockwise with terminal low");

   term_dir_high_a: assert property (
      (dir_mode == CSC_MODE_TERM && reverse_terminal_input)
      |=> dir_ccw
   ) else $error("terminal-only direction not counter-clockwise with terminal high");

   ser_dir_set_a: assert property (
      (dir_mode == CSC_MODE_SER && ser_dir)
      |=> dir_ccw
   ) else $error("serial-only direction not counter-clockwise with serial bit set");

   and_dir_both_a: assert property (
      (dir_mode == CSC_MODE_AND && ser_dir && reverse_terminal_input)
      |=> dir_ccw
   ) else $error("AND direction not counter-clockwise with both sources set");

   or_dir_term_a: assert property (
      (dir_mode == CSC_MODE_OR && reverse_terminal_input)
      |=> dir_ccw
   ) else $error("OR direction ignores the terminal");

   or_dir_ser_a: assert property (
      (dir_mode == CSC_MODE_OR && ser_dir)
      |=> dir_ccw
   ) else $error("OR direction ignores the serial bit");

   // Register side: a write lands at its own edge, a read answers in the next cycle only.
   ser_write_a: assert property (
      (reg_wr && reg_addr == `CSC_REG_SER)
      |=> (ser_q == $past(reg_wdata[`CSC_SER_W-1:0]))
   ) else $error("serial command register did not take the written value");

   mode_hold_a: assert property (
      !(reg_wr && reg_addr == `CSC_REG_MODE)
      |=> $stable(mode_q)
   ) else $error("mode register changed without a write");

   ser_hold_a: assert property (
      !(reg_wr && reg_addr == `CSC_REG_SER)
      |=> $stable(ser_q)
   ) else $error("serial command register changed without a write");

   read_mode_a: assert property (
      (reg_rd && reg_addr == `CSC_REG_MODE)
      |=> (reg_rdata == {{(`CSC_DATA_W-`CSC_MODE_W){1'b0}}, $past(mode_q)})
   ) else $error("mode read data wrong");

   read_ser_a: assert property (
      (reg_rd && reg_addr == `CSC_REG_SER)
      |=> (reg_rdata == {{(`CSC_DATA_W-`CSC_SER_W){1'b0}}, $past(ser_q)})
   ) else $error("serial command read data wrong");

   read_unmapped_a: assert property (
      (reg_rd && reg_addr > `CSC_REG_STAT)
      |=> (reg_rdata == '0)
   ) else $error("unmapped read did not return zero");

   reset_regs_a: assert property (
      @(posedge sys_clk) disable iff (1'b0)
      !nrst |=> (mode_q == `CSC_MODE_RST && ser_q == `CSC_SER_RST && reg_rdata == '0)
   ) else $error("registers not at their reset values after reset");

endmodule

// File: dv/csc_term_src.sv
// Model of the hardwired terminal inputs that face the combiner.
`timescale 1ns/10ps
`include "csc_cfg.svh"

module csc_term_src (
   input wire logic sys_clk,
   output logic reverse_terminal_input,
   output logic [`CSC_CODE_W-1:0] setup_terminal_code,
   output logic [`CSC_CODE_W-1:0] preset_terminal_code
);
   initial begin
      reverse_terminal_input = 1'b0;
      setup_terminal_code = 2'h0;
      preset_terminal_code = 2'h0;
   end

   // Terminal levels change only just after a clock edge, like a debounced input stage would.
   task automatic drive(input logic r, input logic [1:0] s, input logic [1:0] p);
      @(posedge sys_clk);
      reverse_terminal_input <= r;
      setup_terminal_code <= s;
      preset_terminal_code <= p;
   endtask
endmodule

// File: dv/testbench.sv
// Self-checking testbench of the command source combiner.
`timescale 1ns/10ps
`include "csc_cfg.svh"

module testbench;
   logic sys_clk;
   logic nrst;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic rev_t;
   logic [1:0] set_t;
   logic [1:0] pre_t;
   logic dir_ccw;
   logic [2:0] setup_num;
   logic [2:0] preset_num;
   int bad_count;
   int n_compared;

   csc_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reverse_terminal_input(rev_t),
      .setup_terminal_code(set_t), .preset_terminal_code(pre_t), .dir_ccw(dir_ccw),
      .setup_num(setup_num), .preset_num(preset_num));

   csc_term_src u_term (.sys_clk(sys_clk), .reverse_terminal_input(rev_t),
      .setup_terminal_code(set_t), .preset_terminal_code(pre_t));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic stop_test();
      if (bad_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // A register write needs its own edge and then the output edge before results show.
   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   function automatic logic [1:0] mix(input logic [1:0] m, input logic [1:0] t, input logic [1:0] s);
      case (m)
         2'h0: return t;
         2'h1: return s;
         2'h2: return t & s;
         default: return t | s;
      endcase
   endfunction

   task automatic test_reset_values();
      logic [15:0] d;
      check({15'h0, dir_ccw}, 16'h0);
      check({13'h0, setup_num}, 16'h1);
      check({13'h0, preset_num}, 16'h1);
      rd(`CSC_REG_MODE, d);
      check(d, 16'h003c);
      rd(`CSC_REG_SER, d);
      check(d, 16'h0000);
   endtask

   task automatic test_direction();
      for (int m = 0; m < 4; m++) begin
         wr(`CSC_REG_MODE, 16'(m));
         for (int c = 0; c < 4; c++) begin
            wr(`CSC_REG_SER, 16'(c[0]));
            u_term.drive(c[1], 2'h0, 2'h0);
            settle();
            check({15'h0, dir_ccw}, {15'h0, mix(2'(m), {1'b0, c[1]}, {1'b0, c[0]})});
         end
      end
   endtask

   // Setup and preset run different modes at once, so a swapped mode field shows up.
   task automatic test_selection();
      logic [1:0] pm;
      for (int m = 0; m < 4; m++) begin
         pm = 2'(m) ^ 2'h3;
         wr(`CSC_REG_MODE, {10'h0, pm, 2'(m), 2'h0});
         for (int s = 0; s < 4; s++) begin
            wr(`CSC_REG_SER, {11'h0, ~2'(s), 2'(s), 1'b0});
            for (int t = 0; t < 4; t++) begin
               u_term.drive(1'b0, 2'(t), ~2'(t));
               settle();
               check({13'h0, setup_num}, {14'h0, mix(2'(m), 2'(t), 2'(s))} + 16'h1);
               check({13'h0, preset_num}, {14'h0, mix(pm, ~2'(t), ~2'(s))} + 16'h1);
            end
         end
      end
   endtask

   task automatic test_registers();
      logic [15:0] d;
      wr(`CSC_REG_MODE, 16'hffd7);
      wr(`CSC_REG_SER, 16'hfff5);
      u_term.drive(1'b1, 2'h2, 2'h1);
      wr(`CSC_REG_STAT, 16'hffff);
      wr(4'h5, 16'hffff);
      rd(`CSC_REG_MODE, d);
      check(d, 16'h0017);
      @(posedge sys_clk);
      #1;
      check(reg_rdata, 16'h0000);
      rd(`CSC_REG_SER, d);
      check(d, 16'h0015);
      rd(4'h5, d);
      check(d, 16'h0000);
      // Modes: dir OR, setup serial, preset serial; serial dir 1, setup code 2, preset code 2.
      rd(`CSC_REG_STAT, d);
      check(d, {4'h0, 2'h1, 2'h2, 1'b1, 3'h3, 3'h3, 1'b1});
   endtask

   task automatic test_mid_reset();
      @(posedge sys_clk);
      nrst <= 1'b0;
      settle();
      check({15'h0, dir_ccw}, 16'h0);
      check({13'h0, setup_num}, 16'h1);
      check({13'h0, preset_num}, 16'h1);
      u_term.drive(1'b0, 2'h0, 2'h0);
      @(posedge sys_clk);
      nrst <= 1'b1;
      settle();
      test_reset_values();
   endtask

   initial begin
      nrst = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      bad_count = 0;
      n_compared = 0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      settle();
      test_reset_values();
      test_direction();
      test_selection();
      test_registers();
      test_mid_reset();
      stop_test();
   end

   // A run that goes far past its expected length counts as a failure.
   initial begin
      #2500000;
      bad_count++;
      stop_test();
   end
endmodule
